// >>> src/ivw_map.v
// Interrupt vector map with low-power wakeup qualification
`timescale 1ns/1ps
`include "ivw_defs.vh"
module ivw_map (
    input wire core_clk_in,
    input wire reset_n_in,
    input wire [2:0] power_state_in,
    input wire low_power_run_in,
    input wire wfe_exec_in,
    input wire [25:0] src_req_in,
    input wire supply_voltage_detector_in,
    input wire port_e_pin_in,
    input wire port_f_pin_in,
    input wire port_select_setting_in,
    input wire port_b_pin_in,
    input wire port_g_pin_in,
    input wire port_d_pin_in,
    input wire port_h_pin_in,
    input wire clk_switch_in,
    input wire clock_security_in,
    input wire advanced_timer_break_in,
    input wire dac_in,
    input wire comp1_in,
    input wire comp2_in,
    input wire analog_input_converter_in,
    input wire [3:0] second_general_timer_in,
    input wire [1:0] second_serial_port_in,
    input wire [3:0] third_general_timer_in,
    input wire [1:0] third_serial_port_in,
    input wire twi_req_in,
    input wire twi_addr_match_in,
    input wire basic_eight_bit_timer_ovf_in,
    input wire [25:0] int_enable_in,
    input wire [25:0] wake_event_cfg_in,
    input wire vector_fetch_in,
    output wire top_level_request_out,
    output reg irq_out,
    output reg [23:0] vector_addr_out,
    output reg wakeup_out,
    output reg resume_no_vector_out,
    output reg enter_wfe_out
);
    ////////////////////////////////////////////////////////////////////////
    // Vector for a line index
    function [23:0] vec_of;
        input [4:0] idx;
        begin
            vec_of = `IVW_VEC_BASE + `IVW_VEC_STEP * {19'h0, idx};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Shared source combining
    wire port_ef = port_select_setting_in ? port_f_pin_in
                                          : port_e_pin_in;
    wire twi_gated;
    reg [25:0] req;
    wire halt_st = (power_state_in == `IVW_PWR_HALT) ||
                   (power_state_in == `IVW_PWR_AHALT);
    // Address-match only wake while halted
    assign twi_gated = halt_st ? (twi_req_in & twi_addr_match_in)
                               : twi_req_in;
    assign top_level_request_out = second_general_timer_in[1] |
                                   basic_eight_bit_timer_ovf_in;
    always @* begin
        req = src_req_in;
        req[1] = supply_voltage_detector_in | port_ef;
        req[2] = port_b_pin_in | port_g_pin_in;
        req[3] = port_d_pin_in | port_h_pin_in;
        req[13] = clk_switch_in | clock_security_in |
                  advanced_timer_break_in | dac_in;
        req[14] = comp1_in | comp2_in | analog_input_converter_in;
        req[15] = (|second_general_timer_in) |
                  (|second_serial_port_in);
        req[17] = (|third_general_timer_in) |
                  (|third_serial_port_in);
        req[25] = twi_gated;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending flags, cleared by vector fetch of the winning line
    wire [25:0] pend;
    reg [25:0] ack;
    reg [4:0] win_idx;
    reg win_any;
    genvar g;
    generate
        for (g = 0; g < `IVW_LINES; g = g + 1) begin : gp
            ivw_pending u_p (
                .core_clk_in(core_clk_in),
                .reset_n_in(reset_n_in),
                .req_in(req[g]),
                .ack_in(ack[g]),
                .pend_out(pend[g])
            );
        end
    endgenerate

    // Serviceable lines: enabled ones; wake events never vector
    wire [25:0] svc = pend & int_enable_in & ~wake_event_cfg_in;
    wire [25:0] evt = pend & wake_event_cfg_in;
    integer i;
    // Lowest line number wins
    always @* begin
        win_idx = 5'h00;
        win_any = 1'b0;
        ack = 26'h0;
        for (i = `IVW_LINES - 1; i >= 0; i = i - 1) begin
            if (svc[i]) begin
                win_idx = i[4:0];
                win_any = 1'b1;
            end
        end
        if (vector_fetch_in && win_any) begin
            ack[win_idx] = 1'b1;
        end
        if (power_state_in == `IVW_PWR_WFE) begin
            ack = ack | evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wakeup qualification per power state
    reg [25:0] wmask;
    always @* begin
        case (power_state_in)
            `IVW_PWR_HALT: wmask = `IVW_HALT_WAKE_MASK;
            `IVW_PWR_AHALT: wmask = `IVW_HALT_WAKE_MASK;
            `IVW_PWR_WFI: wmask = `IVW_WFI_WAKE_MASK;
            `IVW_PWR_WFE: wmask = `IVW_WFE_WAKE_MASK;
            default: wmask = 26'h0;
        endcase
    end
    // Halt lines seen combinationally from the raw request
    wire halt_wake = halt_st & |(req & `IVW_HALT_WAKE_MASK);
    wire wfe_st = (power_state_in == `IVW_PWR_WFE);
    wire wake_any = |((svc | evt) & wmask);

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs to the core
    always @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
            vector_addr_out <= 24'h000000;
            wakeup_out <= 1'b0;
            resume_no_vector_out <= 1'b0;
            enter_wfe_out <= 1'b0;
        end else begin
            irq_out <= win_any & ~(wfe_st & (|evt));
            vector_addr_out <= vec_of(win_idx);
            wakeup_out <= wake_any | halt_wake;
            resume_no_vector_out <= wfe_st & (|evt);
            enter_wfe_out <= wfe_exec_in & low_power_run_in;
        end
    end
endmodule

// >>> src/ivw_defs.vh
// Constants for the interrupt vector and wakeup map
//
// Function
// - Every request line 4 to 29 has a fixed vector, four bytes apart, line 4 at 0x8018 and line 29 at 0x807c.
// - Line 6 carries the port B/G pin request at 0x8020 and wakes from halt, active-halt and both waits.
// - Line 7 carries the port D/H pin request at 0x8024 and wakes from halt, active-halt and both waits.
// - Line 17 ORs clock switch, clock security, advanced timer break and output converter at 0x804c, waking only from the waits.
// - Line 18 ORs both comparators and the input converter at 0x8050 and wakes from every low-power state.
// - Line 19 ORs second timer update events and second serial port transmit events at 0x8054, waking only from the waits.
// - Line 21 ORs third timer update events and third serial port transmit events at 0x805c, waking only from the waits.
// - The two-wire interface wakes the core from halt or active-halt only on an own-address match.
// - The top-level request is the OR of the second timer and basic eight-bit timer overflows.
// - In wait-for-event state a serviceable request is taken only if enabled and no request set up as a wakeup event is pending.
// - A request set up as a wakeup event wakes the core from wait-for-event without vectoring.
// - The supply voltage detector request is ORed with the port E/F pin request onto line 5 at 0x801c.
// - A port-select setting chooses port E or port F pins for line 5.
`ifndef IVW_DEFS_VH
`define IVW_DEFS_VH
`define IVW_LINES 26
`define IVW_FIRST_LINE 5'h04
`define IVW_VEC_BASE 24'h008018
`define IVW_VEC_STEP 24'h000004
`define IVW_LINE_IDX_W 5
// Power state codes from the core
`define IVW_PWR_RUN 3'h0
`define IVW_PWR_HALT 3'h1
`define IVW_PWR_AHALT 3'h2
`define IVW_PWR_WFI 3'h3
`define IVW_PWR_WFE 3'h4
// Lines able to wake from halt/active-halt (bit n = line n+4)
`define IVW_HALT_WAKE_MASK 26'h2404fff
`define IVW_WFI_WAKE_MASK 26'h3e7ffff
`define IVW_WFE_WAKE_MASK 26'h3ffffff
`endif

// >>> src/ivw_pending.v
// One-line pending flag with level capture and acknowledge
`timescale 1ns/1ps
module ivw_pending (
    input wire core_clk_in,
    input wire reset_n_in,
    input wire req_in,
    input wire ack_in,
    output wire pend_out
);
    reg pend_r;
    // Set wins over clear so a request in the ack cycle survives
    always @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pend_r <= 1'b0;
        end else if (req_in) begin
            pend_r <= 1'b1;
        end else if (ack_in) begin
            pend_r <= 1'b0;
        end
    end
    assign pend_out = pend_r;
endmodule

// >>> tb/ivw_monitor.sv
// Concurrent checks on the vector map ports
`timescale 1ns/1ps
module ivw_monitor (
    input wire core_clk_in, reset_n_in, low_power_run_in, wfe_exec_in,
    input wire comp1_in, port_b_pin_in, twi_req_in, twi_addr_match_in,
    input wire basic_eight_bit_timer_ovf_in, vector_fetch_in, irq_out,
    input wire top_level_request_out, wakeup_out, enter_wfe_out,
    input wire [2:0] power_state_in,
    input wire [3:0] second_general_timer_in,
    input wire [25:0] int_enable_in,
    input wire [23:0] vector_addr_out
);
    wire halt_w = power_state_in == 3'h1;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    a_tli_or: assert property (
        top_level_request_out == (second_general_timer_in[1] |
        basic_eight_bit_timer_ovf_in)) else $error("tli wrong");
    a_vec_range: assert property (
        irq_out |-> vector_addr_out[1:0] == 2'h0 && vector_addr_out >=
        24'h008018 && vector_addr_out <= 24'h00807c) else $error("bad vec");
    a_irq_enable: assert property (
        int_enable_in == 26'h0 |=> !irq_out) else $error("irq unenabled");
    a_irq_holds: assert property (
        irq_out && !vector_fetch_in && !$past(vector_fetch_in) &&
        $stable(int_enable_in) && power_state_in != 3'h4 |=> irq_out)
        else $error("irq dropped");
    a_halt_comp: assert property (
        halt_w && comp1_in |-> ##[1:2] wakeup_out) else $error("no wake");
    a_halt_port: assert property (
        halt_w && port_b_pin_in |-> ##[1:2] wakeup_out) else $error("no wake");
    a_twi_match: assert property (
        halt_w && twi_req_in && twi_addr_match_in |-> ##[1:2] wakeup_out)
        else $error("no twi wake");
    a_wfe_enter: assert property (
        wfe_exec_in && low_power_run_in |-> ##[1:2] enter_wfe_out)
        else $error("no wfe entry");
    c_fetch: cover property (irq_out && vector_fetch_in);
    c_wake: cover property (wakeup_out);
    c_wfe: cover property (enter_wfe_out);
endmodule
bind ivw_map ivw_monitor u_mon (.core_clk_in, .reset_n_in, .low_power_run_in,
    .wfe_exec_in, .comp1_in, .port_b_pin_in, .twi_req_in, .twi_addr_match_in,
    .basic_eight_bit_timer_ovf_in, .vector_fetch_in, .irq_out,
    .top_level_request_out, .wakeup_out, .enter_wfe_out, .power_state_in,
    .second_general_timer_in, .int_enable_in, .vector_addr_out);

// >>> tb/ivw_core_model.sv
// Core model: takes vectors and executes wait-for-event
`timescale 1ns/1ps
module ivw_core_model (
    input wire clk_in,
    input wire rst_n_in,
    input wire irq_in,
    input wire cmd_in,
    input wire lpr_in,
    input wire [1:0] lat_in,
    output reg fetch_out,
    output reg exec_out
);
    reg [2:0] cnt_r;
    // Fetch after lat_in cycles, then hold off while irq falls
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= 3'h0;
            fetch_out <= 1'b0;
            exec_out <= 1'b0;
        end else begin
            cnt_r <= (irq_in || cnt_r != 3'h0) ? cnt_r + 3'h1 : 3'h0;
            fetch_out <= irq_in && cnt_r == {1'b0, lat_in};
            exec_out <= cmd_in && lpr_in;
        end
    end
endmodule

// >>> tb/testbench.sv
// Testbench for the interrupt vector and wakeup map
`timescale 1ns/1ps
module testbench;
    localparam [149:0] LINE_OF = {10'h0, 5'h1d, {6{5'h15}}, {6{5'h13}},
        {3{5'h12}}, {4{5'h11}}, 5'h7, 5'h7, 5'h6, 5'h6, 5'h0, {3{5'h5}}};
    localparam [25:0] BUILT = 26'h202e00e;
    reg clk = 1'b0, rst_n = 1'b0, lpr = 1'b0, cmd = 1'b0;
    reg [29:0] m = 30'h0;
    reg [25:0] raw = 26'h0, en = 26'h0, ev = 26'h0;
    reg [2:0] pw = 3'h0, seen;
    reg [1:0] lat = 2'h0;
    integer num_errors = 0, num_checks = 0, r, ln;
    wire fch, exe, irq, wk, rsm, ent, top_level_request;
    wire [23:0] vec;
    ivw_map u_dut (.core_clk_in(clk), .reset_n_in(rst_n), .power_state_in(pw),
        .low_power_run_in(lpr), .wfe_exec_in(exe), .src_req_in(raw),
        .supply_voltage_detector_in(m[0]), .port_e_pin_in(m[1]),
        .port_f_pin_in(m[2]), .port_select_setting_in(m[3]),
        .port_b_pin_in(m[4]), .port_g_pin_in(m[5]), .port_d_pin_in(m[6]),
        .port_h_pin_in(m[7]), .clk_switch_in(m[8]), .clock_security_in(m[9]),
        .advanced_timer_break_in(m[10]), .dac_in(m[11]), .comp1_in(m[12]),
        .comp2_in(m[13]), .analog_input_converter_in(m[14]),
        .second_general_timer_in(m[18:15]), .second_serial_port_in(m[20:19]),
        .third_general_timer_in(m[24:21]), .third_serial_port_in(m[26:25]),
        .twi_req_in(m[27]), .twi_addr_match_in(m[28]), .int_enable_in(en),
        .basic_eight_bit_timer_ovf_in(m[29]), .wake_event_cfg_in(ev),
        .vector_fetch_in(fch), .top_level_request_out(top_level_request), .irq_out(irq),
        .vector_addr_out(vec), .wakeup_out(wk), .resume_no_vector_out(rsm),
        .enter_wfe_out(ent));
    ivw_core_model u_core (.clk_in(clk), .rst_n_in(rst_n), .irq_in(irq),
        .cmd_in(cmd), .lpr_in(lpr), .lat_in(lat), .fetch_out(fch),
        .exec_out(exe));
    initial forever #2.5 clk = ~clk;
    task chk(input [23:0] got, input [23:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task close_out;
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Hold one power state and source, then look at the wake output
    task wake(input [2:0] p, input [29:0] v, input exp);
        @(posedge clk);
        pw <= p;
        m <= v;
        repeat (3) @(posedge clk);
        #1 chk(24'(wk), 24'(exp));
        pw <= 3'h0;
        m <= 30'h0;
        repeat (10) @(posedge clk);
    endtask
    initial begin
        #20000;
        num_errors = num_errors + 1;
        close_out;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Each row: one source, its line alone enabled, core latency varied
        for (r = 0; r < 56; r = r + 1) begin
            ln = r < 30 ? LINE_OF[r*5 +: 5] : r - 26;
            if (ln > 0 && !(r > 29 && BUILT[r-30])) begin
                @(posedge clk);
                lat <= r[1:0];
                m <= r < 30 ? 30'h1 << r | (r == 2 ? 30'h8 : 30'h0) : 30'h0;
                raw <= r > 29 ? 26'h1 << (r - 30) : 26'h0;
                en <= 26'h1 << (ln - 4);
                repeat (2) @(posedge clk);
                #1 chk(vec, 24'h008018 + 4 * (ln - 4));
                m <= 30'h0;
                raw <= 26'h0;
                repeat (10) @(posedge clk);
            end
        end
        m <= 30'ha;
        en <= 26'h2;
        repeat (3) @(posedge clk);
        #1 chk(24'(irq), 24'h0);
        // Both overflow sources in all four combinations, nothing enabled
        for (r = 0; r < 4; r = r + 1) begin
            @(posedge clk);
            m <= {r[1], 12'h0, r[0], 16'h0};
            en <= 26'h0;
            repeat (2) @(posedge clk);
            #1 chk(24'(top_level_request), 24'(r[1] | r[0]));
            chk(24'(irq), 24'h0);
        end
        @(posedge clk);
        rst_n <= 1'b0;
        m <= 30'h0;
        @(posedge clk);
        #1 chk(vec | 24'({irq, wk, rsm, ent}), 24'h0);
        rst_n <= 1'b1;
        en <= 26'h3ffffff;
        wake(3'h1, 30'h100, 1'b0);
        wake(3'h3, 30'h100, 1'b1);
        wake(3'h1, 30'h1000, 1'b1);
        wake(3'h2, 30'h10, 1'b1);
        wake(3'h2, 30'h80, 1'b1);
        wake(3'h1, 30'h8000, 1'b0);
        wake(3'h1, 30'h200000, 1'b0);
        wake(3'h1, 30'h8000000, 1'b0);
        wake(3'h1, 30'h18000000, 1'b1);
        wake(3'h4, 30'h2000000, 1'b1);
        // Wake event in WAIT_FOR_EVENT_STATE plus a WAIT_FOR_EVENT_STATE executed in low-power run
        @(posedge clk);
        {pw, ev, raw, lpr, cmd} <= {3'h4, 26'h10, 26'h10, 2'h3};
        @(posedge clk);
        cmd <= 1'b0;
        seen = 3'h0;
        repeat (5) @(posedge clk) #1 seen = seen | {rsm, irq, ent};
        chk(24'(seen), 24'h5);
        close_out;
    end
endmodule
